// File: verilog/nvg_pkg.sv
// package: register map, limits and carriers of the pub/sub gate
package nvg_pkg;
    // register byte offsets
    localparam logic [11:0] NVG_OFS_CFG = 12'h000;
    localparam logic [11:0] NVG_OFS_BLOCK = 12'h004;
    localparam logic [11:0] NVG_OFS_PUB_CYC = 12'h008;
    localparam logic [11:0] NVG_OFS_PUB_CFG = 12'h00C;
    localparam logic [11:0] NVG_OFS_SUB_CFG = 12'h010;
    localparam logic [11:0] NVG_OFS_AREA = 12'h014;
    localparam logic [11:0] NVG_OFS_STATUS = 12'h018;
    localparam logic [11:0] NVG_OFS_TOTAL = 12'h01C;
    localparam logic [11:0] NVG_OFS_SUB_CYC = 12'h020;
    localparam logic [11:0] NVG_OFS_LAYOUT = 12'h024;
    localparam logic [11:0] NVG_OFS_TABLE = 12'h100;
    localparam logic [11:0] NVG_TABLE_END = 12'h200;
    // field positions
    localparam int NVG_CFG_FILTER_BIT = 8;
    localparam int NVG_CFG_GRAN_LSB = 12;
    localparam int NVG_BLOCK_LSB = 8;
    localparam int NVG_FIELD_HI_LSB = 16;
    // limits
    localparam int NVG_MAX_ENTRIES = 32;
    localparam int NVG_MAX_GROUPS = 8;
    localparam logic [10:0] NVG_MAX_PAYLOAD = 11'd1500;
    localparam logic [15:0] NVG_MAX_TOTAL = 16'd1024;
    localparam logic [15:0] NVG_DIAG_BASE = 16'd2;
    localparam int NVG_DIAG_PUB_SHIFT = 1;
    localparam int NVG_DIAG_VAR_SHIFT = 2;
    // buffer memory layout, bytes
    localparam logic [15:0] NVG_MEM_SIZE = 16'd8192;
    localparam logic [15:0] NVG_MBX_SIZE = 16'd1024;
    localparam logic [15:0] NVG_MBX_OUT_BASE = 16'h0000;
    localparam logic [15:0] NVG_MBX_IN_BASE = 16'h0400;
    localparam logic [15:0] NVG_PUB_BASE = 16'h0800;
    localparam logic [1:0] NVG_NUM_BUFFERS = 2'd3;
    // reset values
    localparam logic [15:0] NVG_CFG_RESET = 16'h0000;
    localparam logic [15:0] NVG_BLOCK_RESET = 16'h0000;
    localparam logic [13:0] NVG_AREA_RESET = 14'd1024;
    localparam logic [31:0] NVG_ZERO32 = 32'h0000_0000;

    // publisher frame request
    typedef struct packed {
        logic [4:0] index;
        logic [10:0] length;
    } nvg_pub_req_t;

    // header of a received subscriber variable
    typedef struct packed {
        logic [47:0] net_id;
        logic [15:0] var_id;
        logic [15:0] cycle;
    } nvg_sub_hdr_t;

    typedef enum logic [1:0] {
        NVG_SUB_IDLE = 2'b00,
        NVG_SUB_PD = 2'b01,
        NVG_SUB_MBX = 2'b10,
        NVG_SUB_DROP = 2'b11
    } nvg_sub_route_t;
endpackage

// File: verilog/nvg_group_block.sv
// group decoder: is a publisher frame inside a blocked group
`timescale 1ns/1ns
module nvg_group_block
    import nvg_pkg::*;
(
    input wire logic [3:0] gran, // frames per group, 0 = off
    input wire logic [7:0] mask, // one bit per group
    input wire logic [4:0] frame, // zero based frame index
    output logic blocked // frame suppressed this cycle
);
    logic [8:0] lo;
    logic [8:0] hi;

    // group k spans frames k*gran .. (k+1)*gran-1
    always_comb begin
        blocked = 1'b0;
        lo = 9'd0;
        hi = 9'd0;
        for (int k = 0; k < NVG_MAX_GROUPS; k++) begin
            lo = 9'(k) * {5'd0, gran};
            hi = lo + {5'd0, gran};
            if (gran != 4'd0 && mask[k] && {4'd0, frame} >= lo &&
                {4'd0, frame} < hi) begin
                blocked = 1'b1;
            end
        end
    end
endmodule

// File: verilog/nvg_pubsub_gate.sv
// pub/sub network variable gate: apb registers, publish gate, filter
//
// Function
// - each publisher is its own frame, payload at most 1500 bytes
// - every publisher variable carries payload plus diagnostic data
// - at most 32 publishers and subscribers per device
// - total data per direction, diagnostics included, at most 1024
// - publisher diagnostic bytes are two plus two per publisher
// - subscriber diagnostic bytes are two plus four per variable
// - 8 kbyte memory: two 1 kbyte mailboxes, triple pub/sub areas
// - mailbox sizes fixed, only pub and sub areas may be resized
// - link indicator shows only the cable connection state
// - no send on change or divider modes, blocking replaces them
// - top nibble of config gives frames per group, zero disables
// - upper eight control bits block their groups this cycle
// - control bit 8 plus k selects group k plus one
// - bit positions count from zero at the least significant bit
// - online config changes revert to defaults on restart; the subscriber match table keeps its entries
// - matching subscribers go to cyclic process data
// - filter bit set discards mismatches, else they go to mailbox
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module nvg_pubsub_gate
    import nvg_pkg::*;
(
    input wire logic core_clk, // 100 mhz system clock
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic bus_restart, // fieldbus restart pulse
    input wire logic cable_up, // phy cable detect pin, async
    input wire logic cycle_start, // process data cycle pulse
    input wire logic pub_valid, // publisher frame request
    input wire nvg_pub_req_t pub_req, // frame index and payload length
    output logic pub_ready, // request accepted
    output logic pub_send, // frame may be sent, pulse
    output logic pub_skip, // frame suppressed, pulse
    output logic [15:0] pub_cycle, // cycle counter to insert
    input wire logic sub_valid, // received subscriber variable
    input wire nvg_sub_hdr_t sub_hdr, // its header
    output nvg_sub_route_t sub_route, // routing decision, one cycle
    output logic [4:0] sub_entry, // matching table entry
    output logic link_led // cable indicator
);
    // software registers
    logic [15:0] cfg_q; // gran nibble and filter bit
    logic [15:0] block_q; // publisher_block_control
    logic [15:0] pub_cyc_q; // publisher_cycle_counter
    logic [5:0] npub_q;
    logic [10:0] pub_bytes_q;
    logic [5:0] nsub_q;
    logic [7:0] nvar_q;
    logic [10:0] sub_bytes_q;
    logic [13:0] pub_area_q;
    logic [13:0] sub_area_q;
    logic [15:0] sub_cyc_q; // subscriber_cycle_counter
    logic [63:0] table_q [NVG_MAX_ENTRIES];
    // per-cycle snapshot
    logic [7:0] mask_cur_q;
    logic [3:0] gran_cur_q;
    // link sync
    logic cable_s1_q;
    logic cable_s2_q;
    logic cable_s3_q;
    logic link_q;
    // apb
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic setup;
    logic wr_en;
    logic restart;
    logic [31:0] rd_d;
    logic err_d;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign restart = bus_restart;

    // sizing and accounting
    logic [15:0] pub_diag;
    logic [15:0] sub_diag;
    logic [15:0] pub_total;
    logic [15:0] sub_total;
    logic pub_over;
    logic sub_over;
    logic count_err;
    logic [15:0] sub_base;
    logic [16:0] mem_used;
    logic mem_err;
    logic cfg_bad;

    // diagnostic reserve per direction
    assign pub_diag = NVG_DIAG_BASE +
        16'({10'd0, npub_q} << NVG_DIAG_PUB_SHIFT);
    assign sub_diag = NVG_DIAG_BASE +
        16'({8'd0, nvar_q} << NVG_DIAG_VAR_SHIFT);
    assign pub_total = {5'd0, pub_bytes_q} + pub_diag;
    assign sub_total = {5'd0, sub_bytes_q} + sub_diag;
    assign pub_over = pub_total > NVG_MAX_TOTAL;
    assign sub_over = sub_total > NVG_MAX_TOTAL;
    assign count_err = (npub_q > 6'(NVG_MAX_ENTRIES)) ||
        (nsub_q > 6'(NVG_MAX_ENTRIES));
    // mailboxes fixed, each triple buffered area follows the last
    assign sub_base = NVG_PUB_BASE +
        16'({2'd0, pub_area_q} * NVG_NUM_BUFFERS);
    assign mem_used = {1'b0, sub_base} +
        17'({3'd0, sub_area_q} * NVG_NUM_BUFFERS);
    assign mem_err = mem_used > {1'b0, NVG_MEM_SIZE};
    assign cfg_bad = pub_over | sub_over | count_err | mem_err;

    // cable pin through three flops, changes when the last two agree
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cable_s1_q <= 1'b0;
            cable_s2_q <= 1'b0;
            cable_s3_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            cable_s1_q <= cable_up;
            cable_s2_q <= cable_s1_q;
            cable_s3_q <= cable_s2_q;
            if (cable_s2_q == cable_s3_q) begin
                link_q <= cable_s3_q;
            end
        end
    end
    // led shows cable only, never variable connections
    assign link_led = link_q;

    // control registers, restart brings defaults back
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= NVG_CFG_RESET;
            block_q <= NVG_BLOCK_RESET;
            pub_cyc_q <= 16'h0000;
            npub_q <= 6'd0;
            pub_bytes_q <= 11'd0;
            nsub_q <= 6'd0;
            nvar_q <= 8'd0;
            sub_bytes_q <= 11'd0;
            pub_area_q <= NVG_AREA_RESET;
            sub_area_q <= NVG_AREA_RESET;
        end else if (restart) begin
            cfg_q <= NVG_CFG_RESET;
            block_q <= NVG_BLOCK_RESET;
            pub_cyc_q <= 16'h0000;
            npub_q <= 6'd0;
            pub_bytes_q <= 11'd0;
            nsub_q <= 6'd0;
            nvar_q <= 8'd0;
            sub_bytes_q <= 11'd0;
            pub_area_q <= NVG_AREA_RESET;
            sub_area_q <= NVG_AREA_RESET;
        end else if (wr_en) begin
            case (paddr)
                NVG_OFS_CFG: cfg_q <= pwdata[15:0];
                NVG_OFS_BLOCK: block_q <= pwdata[15:0];
                // counter is only ever what software last wrote, or zero after reset or restart
                NVG_OFS_PUB_CYC: pub_cyc_q <= pwdata[15:0];
                NVG_OFS_PUB_CFG: begin
                    npub_q <= pwdata[5:0];
                    pub_bytes_q <= pwdata[26:16];
                end
                NVG_OFS_SUB_CFG: begin
                    nsub_q <= pwdata[5:0];
                    nvar_q <= pwdata[15:8];
                    sub_bytes_q <= pwdata[26:16];
                end
                // only the process data areas are sizeable
                NVG_OFS_AREA: begin
                    pub_area_q <= pwdata[13:0];
                    sub_area_q <= pwdata[29:16];
                end
                default: begin
                end
            endcase
        end
    end

    // subscriber match table, two words per entry
    always_ff @(posedge core_clk) begin
        // a misaligned word is refused on the bus, so it must not land here
        if (wr_en && paddr >= NVG_OFS_TABLE && paddr < NVG_TABLE_END &&
            paddr[1:0] == 2'b00) begin
            if (paddr[2]) begin
                table_q[paddr[7:3]][63:32] <= pwdata;
            end else begin
                table_q[paddr[7:3]][31:0] <= pwdata;
            end
        end
    end

    // read mux and decode, evaluated in the setup phase
    always_comb begin
        rd_d = NVG_ZERO32;
        err_d = 1'b0;
        case (paddr)
            NVG_OFS_CFG: rd_d = {16'h0000, cfg_q};
            NVG_OFS_BLOCK: rd_d = {16'h0000, block_q};
            NVG_OFS_PUB_CYC: rd_d = {16'h0000, pub_cyc_q};
            NVG_OFS_PUB_CFG: rd_d = {5'd0, pub_bytes_q, 10'd0, npub_q};
            NVG_OFS_SUB_CFG:
                rd_d = {5'd0, sub_bytes_q, nvar_q, 2'd0, nsub_q};
            NVG_OFS_AREA: rd_d = {2'd0, sub_area_q, 2'd0, pub_area_q};
            // zero in bit 0 means cable present
            NVG_OFS_STATUS: rd_d = {27'd0, mem_err, count_err, sub_over,
                pub_over, ~link_q};
            NVG_OFS_TOTAL: rd_d = {sub_total, pub_total};
            NVG_OFS_SUB_CYC: rd_d = {16'h0000, sub_cyc_q};
            NVG_OFS_LAYOUT: rd_d = {sub_base, NVG_PUB_BASE};
            default: begin
                if (paddr >= NVG_OFS_TABLE && paddr < NVG_TABLE_END &&
                    paddr[1:0] == 2'b00) begin
                    rd_d = paddr[2] ? table_q[paddr[7:3]][63:32] :
                        table_q[paddr[7:3]][31:0];
                end else begin
                    err_d = 1'b1;
                end
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            err_d = 1'b1;
        end
    end

    // answer registered at setup so data leaves a flop, no wait states
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= NVG_ZERO32;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? NVG_ZERO32 : rd_d;
            pslverr_q <= err_d;
        end
    end
    assign prdata = prdata_q;
    assign pready = psel & penable;
    assign pslverr = psel & penable & pslverr_q;

    // snapshot of blocking word at each cycle start
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_cur_q <= 8'h00;
            gran_cur_q <= 4'h0;
        end else if (restart) begin
            mask_cur_q <= 8'h00;
            gran_cur_q <= 4'h0;
        end else if (cycle_start) begin
            // later writes wait for the next cycle
            mask_cur_q <= block_q[15:NVG_BLOCK_LSB];
            gran_cur_q <= cfg_q[15:NVG_CFG_GRAN_LSB];
        end
    end

    // publish gate
    logic frame_blocked;
    logic send_d;
    logic pub_send_q;
    logic pub_skip_q;
    logic [15:0] pub_cycle_q;

    // bit 8+k of the control word maps to mask bit k, group k+1
    nvg_group_block u_group (
        .gran(gran_cur_q),
        .mask(mask_cur_q),
        .frame(pub_req.index),
        .blocked(frame_blocked)
    );

    assign pub_ready = 1'b1;
    // one frame per publisher; beside the count, payload and config checks only
    // cyclic blocking decides, no change detection or divider is offered
    assign send_d = ~frame_blocked & ~cfg_bad &
        ({1'b0, pub_req.index} < npub_q) &
        (pub_req.length <= NVG_MAX_PAYLOAD);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pub_send_q <= 1'b0;
            pub_skip_q <= 1'b0;
            pub_cycle_q <= 16'h0000;
        end else begin
            pub_send_q <= pub_valid & send_d;
            pub_skip_q <= pub_valid & ~send_d;
            if (pub_valid) begin
                pub_cycle_q <= pub_cyc_q;
            end
        end
    end
    assign pub_send = pub_send_q;
    assign pub_skip = pub_skip_q;
    assign pub_cycle = pub_cycle_q;

    // subscriber filter against configured entries
    logic hit;
    logic [4:0] hit_idx;
    nvg_sub_route_t route_q;
    logic [4:0] entry_q;

    always_comb begin
        hit = 1'b0;
        hit_idx = 5'd0;
        for (int i = NVG_MAX_ENTRIES - 1; i >= 0; i--) begin
            if (6'(i) < nsub_q &&
                table_q[i][63:16] == sub_hdr.net_id[47:0] &&
                table_q[i][15:0] == sub_hdr.var_id) begin
                hit = 1'b1;
                hit_idx = 5'(i);
            end
        end
    end

    // mismatches flood the mailbox unless the filter bit is set
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            route_q <= NVG_SUB_IDLE;
            entry_q <= 5'd0;
            sub_cyc_q <= 16'h0000;
        end else if (!sub_valid) begin
            route_q <= NVG_SUB_IDLE;
        end else if (hit) begin
            route_q <= NVG_SUB_PD;
            entry_q <= hit_idx;
            sub_cyc_q <= sub_hdr.cycle;
        end else if (cfg_q[NVG_CFG_FILTER_BIT]) begin
            route_q <= NVG_SUB_DROP;
        end else begin
            route_q <= NVG_SUB_MBX;
        end
    end
    assign sub_route = route_q;
    assign sub_entry = entry_q;
endmodule

// File: verification/nvg_chk.sv
// checker: port level assertions of the pub/sub gate
`timescale 1ns/1ns
module nvg_chk
    import nvg_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic reset_n, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic [11:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic cable_up, // cable pin
    input wire logic pub_valid, // frame request
    input wire nvg_pub_req_t pub_req, // request fields
    input wire logic pub_send, // frame sent
    input wire logic pub_skip, // frame suppressed
    input wire logic sub_valid, // subscriber in
    input wire nvg_sub_route_t sub_route, // routing decision
    input wire logic link_led // cable indicator
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // zero wait states, ready only in the access phase
    apb_ready_a: assert property (
        pready == (psel && penable)) else $error("pready off phase");
    // a misaligned word access is refused
    apb_align_a: assert property (
        psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access accepted");
    // every request gets exactly one verdict next cycle
    pub_answer_a: assert property (
        pub_valid |=> pub_send != pub_skip) else $error("no verdict");
    // no frame leaves without a request
    pub_quiet_a: assert property (
        !pub_valid |=> !pub_send && !pub_skip)
        else $error("verdict without request");
    // oversize payload never sent
    pub_long_a: assert property (
        pub_valid && pub_req.length > NVG_MAX_PAYLOAD |=> pub_skip)
        else $error("oversize frame sent");
    // each subscriber is routed somewhere
    sub_answer_a: assert property (
        sub_valid |=> sub_route != NVG_SUB_IDLE) else $error("unrouted");
    // no routing without a subscriber
    sub_idle_a: assert property (
        !sub_valid |=> sub_route == NVG_SUB_IDLE) else $error("stray route");
    // indicator follows the cable within the synchroniser delay
    link_up_a: assert property (
        cable_up [*6] |=> link_led) else $error("led missed cable up");
    link_down_a: assert property (
        !cable_up [*6] |=> !link_led) else $error("led missed cable down");
endmodule

// File: verification/nvg_far_model.sv
// far side model: feeds publisher frames and received subscribers
`timescale 1ns/1ns
module nvg_far_model
    import nvg_pkg::*;
(
    input wire logic core_clk, // system clock
    output logic pub_valid, // frame request
    output nvg_pub_req_t pub_req, // index and length
    input wire logic pub_ready, // request accepted
    input wire logic pub_send, // frame sent
    input wire logic pub_skip, // frame suppressed
    output logic sub_valid, // subscriber in
    output nvg_sub_hdr_t sub_hdr, // its header
    input wire nvg_sub_route_t sub_route // routing decision
);
    initial begin
        pub_valid = 1'b0;
        sub_valid = 1'b0;
        pub_req = '0;
        sub_hdr = '0;
    end
    // request held until accepted; idle lines then carry junk
    task automatic pub(input logic [4:0] i, input logic [10:0] n,
            output logic s, output logic k);
        @(posedge core_clk);
        pub_valid <= 1'b1;
        pub_req <= '{index: i, length: n};
        do @(posedge core_clk); while (pub_ready !== 1'b1);
        pub_valid <= 1'b0;
        pub_req <= ~pub_req;
        @(negedge core_clk);
        s = pub_send;
        k = pub_skip;
    endtask
    // one received variable, mirrored from a sender's publisher
    task automatic sub(input nvg_sub_hdr_t h, output nvg_sub_route_t r);
        @(posedge core_clk);
        sub_valid <= 1'b1;
        sub_hdr <= h;
        @(posedge core_clk);
        sub_valid <= 1'b0;
        sub_hdr <= ~h;
        @(negedge core_clk);
        r = sub_route;
    endtask
endmodule

// File: verification/tb.sv
// testbench of the pub/sub gate: apb tasks, random and corner cases
`timescale 1ns/1ns
module tb;
    import nvg_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic bus_restart = 1'b0, cable_up = 1'b1, cycle_start = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pub_ready, pub_send, pub_skip, link_led;
    logic pub_valid, sub_valid, err, s, k;
    nvg_pub_req_t pub_req;
    nvg_sub_hdr_t sub_hdr, h;
    nvg_sub_route_t sub_route, rt;
    logic [15:0] pub_cycle, pb, nv, cy;
    logic [4:0] sub_entry;
    logic [5:0] np;
    logic [3:0] g;
    logic [7:0] m;
    int fails = 0, check_count = 0, cyc = 0;
    nvg_pubsub_gate u_dut (.core_clk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_restart,
        .cable_up, .cycle_start, .pub_valid, .pub_req, .pub_ready,
        .pub_send, .pub_skip, .pub_cycle, .sub_valid, .sub_hdr,
        .sub_route, .sub_entry, .link_led);
    nvg_far_model u_far (.core_clk, .pub_valid, .pub_req, .pub_ready,
        .pub_send, .pub_skip, .sub_valid, .sub_hdr, .sub_route);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, got);
        check_count++;
        if (got !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", what, e, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one-cycle pulse on cycle_start, or on bus_restart when rst is set
    task automatic tick(input logic rst);
        @(posedge core_clk);
        if (rst) begin
            bus_restart <= 1'b1;
        end else begin
            cycle_start <= 1'b1;
        end
        @(posedge core_clk);
        bus_restart <= 1'b0;
        cycle_start <= 1'b0;
    endtask
    function automatic logic blk(logic [3:0] g, logic [7:0] m, int i);
        return g != 4'h0 && i / g < 8 && m[i / g];
    endfunction
    initial begin
        void'($urandom(63));
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        apb(0, NVG_OFS_LAYOUT, 0);
        chk("layout", 32'h1400_0800, rd);
        apb(0, NVG_OFS_AREA, 0);
        chk("area", 32'h0400_0400, rd);
        // only the process areas move when resized
        apb(1, NVG_OFS_AREA, 32'h0200_0200);
        apb(0, NVG_OFS_LAYOUT, 0);
        chk("resized", 32'h0E00_0800, rd);
        apb(1, NVG_OFS_AREA, 32'h0400_0400);
        apb(0, 12'h028, 0);
        chk("unmapped", 1, err);
        apb(0, 12'h002, 0);
        chk("misaligned", 1, err);
        repeat (4) begin
            pb = $urandom % 500;
            np = $urandom % 32 + 1;
            nv = $urandom % 60;
            apb(1, NVG_OFS_PUB_CFG, {5'h00, pb[10:0], 10'h000, np});
            apb(1, NVG_OFS_SUB_CFG, {5'h00, pb[10:0], nv[7:0], 2'b00, np});
            apb(0, NVG_OFS_TOTAL, 0);
            chk("pub total", pb + 2 + 2 * np, rd[15:0]);
            chk("sub total", pb + 2 + 4 * nv, rd[31:16]);
        end
        apb(1, NVG_OFS_PUB_CFG, 32'h0064_000C);
        apb(1, NVG_OFS_SUB_CFG, 32'h0008_0101);
        apb(0, NVG_OFS_STATUS, 0);
        chk("status", 0, rd[4:0]);
        cy = $urandom;
        apb(1, NVG_OFS_PUB_CYC, {16'h0000, cy});
        // no blocking, the documented example, then a random group size
        for (int t = 0; t < 3; t++) begin
            g = (t == 0) ? 4'h0 : (t == 1) ? 4'h2 : 4'h1 + $urandom % 15;
            m = (t == 1) ? 8'h04 : $urandom;
            apb(1, NVG_OFS_CFG, {16'h0000, g, 12'h000});
            apb(1, NVG_OFS_BLOCK, {16'h0000, m, 8'h00});
            tick(1'b0);
            // a late word change must wait for the next cycle
            apb(1, NVG_OFS_BLOCK, {16'h0000, ~m, 8'h00});
            for (int i = 0; i < 14; i++) begin
                u_far.pub(i, 11'd1500, s, k);
                chk("skip", blk(g, m, i) || i >= 12, k);
                chk("send", !k, s);
                chk("cycle", cy, pub_cycle);
            end
        end
        tick(1'b1);
        apb(0, NVG_OFS_CFG, 0);
        chk("cfg restart", 0, rd);
        // restart cleared the counts too, so the startup list reloads them
        apb(1, NVG_OFS_PUB_CFG, 32'h0064_000C);
        apb(1, NVG_OFS_SUB_CFG, 32'h0008_0101);
        u_far.pub(0, 11'd1500, s, k);
        chk("max payload", 1, s);
        u_far.pub(0, 11'd1501, s, k);
        chk("oversize", 1, k);
        apb(1, NVG_OFS_PUB_CFG, 32'h03FF_0001);
        apb(0, NVG_OFS_STATUS, 0);
        chk("over", 5'b00010, rd[4:0]);
        u_far.pub(0, 11'd100, s, k);
        chk("over skip", 1, k);
        apb(1, NVG_OFS_PUB_CFG, 32'h0064_000C);
        h = 80'({$urandom, $urandom, $urandom});
        // entry word 0 holds net_id[15:0] and var_id, word 1 net_id[47:16]
        apb(1, NVG_OFS_TABLE, {h.net_id[15:0], h.var_id});
        apb(1, NVG_OFS_TABLE + 12'h004, h.net_id[47:16]);
        u_far.sub(h, rt);
        chk("match", NVG_SUB_PD, rt);
        chk("entry", 0, sub_entry);
        apb(0, NVG_OFS_SUB_CYC, 0);
        chk("sub cycle", h.cycle, rd);
        h.var_id = h.var_id ^ 16'h0001;
        u_far.sub(h, rt);
        chk("to mailbox", NVG_SUB_MBX, rt);
        apb(1, NVG_OFS_CFG, 32'h0000_0100);
        u_far.sub(h, rt);
        chk("dropped", NVG_SUB_DROP, rt);
        @(posedge core_clk);
        cable_up <= 1'b0;
        repeat (8) @(posedge core_clk);
        apb(0, NVG_OFS_STATUS, 0);
        chk("link state", 1, rd[0]);
        chk("led", 0, link_led);
        print_verdict();
    end
endmodule
bind nvg_pubsub_gate nvg_chk u_chk (.core_clk, .reset_n, .psel, .penable,
    .paddr, .pready, .pslverr, .cable_up, .pub_valid, .pub_req, .pub_send,
    .pub_skip, .sub_valid, .sub_route, .link_led);
